// ===== src/ebl_consts.svh
`ifndef EBL_CONSTS_SVH
`define EBL_CONSTS_SVH

// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define EBL_OFF_CTRL 12'h000
`define EBL_OFF_TIMING 12'h004
`define EBL_OFF_ADDR 12'h008
`define EBL_OFF_WDATA 12'h00c
`define EBL_OFF_CMD 12'h010
`define EBL_OFF_STATUS 12'h014
`define EBL_OFF_RDATA 12'h018

// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define EBL_CTRL_W 10
`define EBL_TIM_W 30
`define EBL_CTRL_RST 10'h202
`define EBL_TIM_RST 30'h39e7_9238
`define EBL_CMD_START 0
`define EBL_CMD_WRITE 1
`define EBL_ST_BUSY 0
`define EBL_ST_ERR 1
`define EBL_ST_DONE 2

// ----------------------------------------
// Port-size codes and idle pad levels
// ----------------------------------------
`define EBL_DSZ_16LO 3'h1
`define EBL_DSZ_16HI 3'h2
`define EBL_DSZ_32 3'h3
`define EBL_DSZ_8B0 3'h4
`define EBL_DSZ_8B1 3'h5
`define EBL_DSZ_8B3 3'h7
`define EBL_STRB_IDLE 8'hff

`endif

// ===== src/ebl_pkg.sv
package ebl_pkg;

	// ----------------------------------------
	// Types
	// ----------------------------------------
	// Access configuration, as stored in the control register
	typedef struct packed {
		logic [3:0] len;
		logic [1:0] div;
		logic [2:0] port_size_code;
		logic mux;
	} ebl_cfg_t;

	// Strobe windows in bus-clock cycles: on at start, off at end
	typedef struct packed {
		logic [2:0] be_off;
		logic [2:0] be_on;
		logic [2:0] we_off;
		logic [2:0] we_on;
		logic [2:0] oe_off;
		logic [2:0] oe_on;
		logic [2:0] adv_off;
		logic [2:0] adv_on;
		logic [2:0] cs_off;
		logic [2:0] cs_on;
	} ebl_tim_t;

	// Control strobes toward the memory, all active low
	typedef struct packed {
		logic chip_select_n;
		logic write_enable_n;
		logic output_enable_n;
		logic address_valid_n;
		logic [3:0] byte_lane_enable_n;
	} ebl_strb_t;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_WAIT = 3'b010,
		ST_RUN = 3'b100
	} ebl_state_t;

endpackage

// ===== src/ebl_top.sv
// The implementer's own choices: the register offsets and register access over APB.
`timescale 1ns/1ps
`include "ebl_consts.svh"
module ebl_top (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic pready,
	output logic [31:0] prdata,
	output logic pslverr,
	output logic bus_clk,
	output ebl_pkg::ebl_strb_t strobe,
	output logic [9:0] addr_hi,
	output logic [15:0] da_o,
	output logic [1:0] da_oe_n,
	input wire logic [15:0] da_i,
	output logic [15:0] nand_shared_data_pins_o,
	output logic [1:0] nand_shared_data_pins_oe_n,
	input wire logic [15:0] nand_shared_data_pins_i,
	input wire logic nand_busy,
	output logic nand_claim,
	output logic [15:0] d_hi_o,
	output logic [1:0] d_hi_oe_n,
	input wire logic [15:0] d_hi_i
);
	import ebl_pkg::*;

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	// Byte lanes used by a mode; zero marks an unsupported code
	function automatic logic [3:0] lane_mask(input logic mux,
		input logic [2:0] port_size_code);
		lane_mask = 4'h0;
		if (mux) begin
			if (port_size_code == `EBL_DSZ_16LO) lane_mask = 4'h3;
			if (port_size_code == `EBL_DSZ_32) lane_mask = 4'hf;
		end else begin
			case (port_size_code)
				`EBL_DSZ_8B0: lane_mask = 4'h1;
				`EBL_DSZ_8B1: lane_mask = 4'h2;
				`EBL_DSZ_8B3: lane_mask = 4'h8;
				`EBL_DSZ_16LO: lane_mask = 4'h3;
				`EBL_DSZ_16HI: lane_mask = 4'hc;
				`EBL_DSZ_32: lane_mask = 4'hf;
				default: lane_mask = 4'h0;
			endcase
		end
	endfunction

	// Shared pads carry the low half when separate, the high when muxed
	function automatic logic uses_nand(input ebl_cfg_t c);
		logic [3:0] m;
		m = lane_mask(c.mux, c.port_size_code);
		uses_nand = c.mux ? (|m[3:2]) : (|m[1:0]);
	endfunction

	function automatic logic win(input logic [3:0] c,
		input logic [2:0] on, input logic [2:0] off);
		win = (c >= {1'b0, on}) && (c < {1'b0, off});
	endfunction

	// ----------------------------------------
	// APB slave
	// ----------------------------------------
	ebl_cfg_t ctrl_q, ctrl_d;
	ebl_tim_t tim_q, tim_d;
	logic [31:0] addr_q, addr_d, wdat_q, wdat_d, rdat_q, rdat_d;
	logic [31:0] prdata_d;
	logic pready_d, pslverr_d, acc, wr, start, dir_req;
	logic err_q, err_d, done_q, done_d, err_set, done_set;
	ebl_state_t state_q, state_d;

	// One wait state keeps pready, prdata and pslverr registered
	always_comb begin
		acc = psel && penable && pready;
		wr = acc && pwrite;
		pready_d = psel && penable && !pready;
		ctrl_d = ctrl_q;
		tim_d = tim_q;
		addr_d = addr_q;
		wdat_d = wdat_q;
		start = wr && (paddr == `EBL_OFF_CMD) && pwdata[`EBL_CMD_START];
		dir_req = pwdata[`EBL_CMD_WRITE];
		if (wr && paddr == `EBL_OFF_CTRL)
			ctrl_d = ebl_cfg_t'(pwdata[`EBL_CTRL_W-1:0]);
		if (wr && paddr == `EBL_OFF_TIMING)
			tim_d = ebl_tim_t'(pwdata[`EBL_TIM_W-1:0]);
		if (wr && paddr == `EBL_OFF_ADDR)
			addr_d = pwdata;
		if (wr && paddr == `EBL_OFF_WDATA)
			wdat_d = pwdata;
		// Sticky flags: an event in the clearing cycle still sets
		err_d = err_q;
		done_d = done_q;
		if (wr && paddr == `EBL_OFF_STATUS) begin
			if (pwdata[`EBL_ST_ERR]) err_d = 1'b0;
			if (pwdata[`EBL_ST_DONE]) done_d = 1'b0;
		end
		if (err_set) err_d = 1'b1;
		if (done_set) done_d = 1'b1;
		prdata_d = 32'h0000_0000;
		pslverr_d = 1'b0;
		case (paddr)
			`EBL_OFF_CTRL: prdata_d[`EBL_CTRL_W-1:0] = ctrl_q;
			`EBL_OFF_TIMING: prdata_d[`EBL_TIM_W-1:0] = tim_q;
			`EBL_OFF_ADDR: prdata_d = addr_q;
			`EBL_OFF_WDATA: prdata_d = wdat_q;
			`EBL_OFF_CMD: prdata_d = 32'h0000_0000;
			`EBL_OFF_STATUS: prdata_d = {29'h0, done_q, err_q,
				state_q != ST_IDLE};
			`EBL_OFF_RDATA: prdata_d = rdat_q;
			default: pslverr_d = pready_d;
		endcase
		if (!pready_d) prdata_d = 32'h0000_0000;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
			ctrl_q <= `EBL_CTRL_RST;
			tim_q <= `EBL_TIM_RST;
			addr_q <= 32'h0000_0000;
			wdat_q <= 32'h0000_0000;
			err_q <= 1'b0;
			done_q <= 1'b0;
		end else begin
			pready <= pready_d;
			prdata <= prdata_d;
			pslverr <= pslverr_d;
			ctrl_q <= ctrl_d;
			tim_q <= tim_d;
			addr_q <= addr_d;
			wdat_q <= wdat_d;
			err_q <= err_d;
			done_q <= done_d;
		end
	end

	// ----------------------------------------
	// Bus clock divider
	// ----------------------------------------
	logic [1:0] dcnt_q, dcnt_d;
	logic [2:0] half;
	logic tick, bclk_d;

	// Divide 0 cannot toggle from a flop at pclk rate; pin stays high
	always_comb begin
		tick = (dcnt_q == ctrl_q.div);
		dcnt_d = tick ? 2'd0 : dcnt_q + 2'd1;
		half = ({1'b0, ctrl_q.div} + 3'd1) >> 1;
		bclk_d = (ctrl_q.div == 2'd0) || ({1'b0, dcnt_d} < half);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dcnt_q <= 2'd0;
			bus_clk <= 1'b1;
		end else begin
			dcnt_q <= dcnt_d;
			bus_clk <= bclk_d;
		end
	end

	// ----------------------------------------
	// Access sequencer and lane mapping
	// ----------------------------------------
	ebl_cfg_t cfg_q, cfg_d;
	ebl_tim_t tw_q, tw_d;
	ebl_strb_t strb_d;
	logic [3:0] cyc_q, cyc_d, last, m, lm;
	logic [31:0] aq_q, aq_d, wq_q, wq_d, cap;
	logic dir_q, dir_d, claim_d, aph;
	logic [15:0] lo_in, hi_in, da_d, nd_d, dh_d;
	logic [1:0] da_oe_d, nd_oe_d, dh_oe_d, lo_en, hi_en;
	logic [9:0] ahi_d;

	always_comb begin
		state_d = state_q;
		cfg_d = cfg_q;
		tw_d = tw_q;
		aq_d = aq_q;
		wq_d = wq_q;
		dir_d = dir_q;
		cyc_d = cyc_q;
		rdat_d = rdat_q;
		err_set = 1'b0;
		done_set = 1'b0;
		lm = lane_mask(ctrl_q.mux, ctrl_q.port_size_code);
		m = lane_mask(cfg_q.mux, cfg_q.port_size_code);
		last = (cfg_q.len == 4'd0) ? 4'd0 : cfg_q.len - 4'd1;
		lo_in = cfg_q.mux ? da_i : nand_shared_data_pins_i;
		hi_in = cfg_q.mux ? nand_shared_data_pins_i : d_hi_i;
		cap = {hi_in, lo_in} & {{8{m[3]}}, {8{m[2]}},
			{8{m[1]}}, {8{m[0]}}};
		case (state_q)
			ST_IDLE: begin
				if (start && lm == 4'h0) err_set = 1'b1;
				else if (start) begin
					cfg_d = ctrl_q;
					tw_d = tim_q;
					aq_d = addr_q;
					wq_d = wdat_q;
					dir_d = dir_req;
					state_d = ST_WAIT;
				end
			end
			ST_WAIT: begin
				err_set = start;
				// Wait for the NAND side to leave the shared pads
				if (tick && !(uses_nand(cfg_q) && nand_busy)) begin
					cyc_d = 4'd0;
					state_d = ST_RUN;
				end
			end
			ST_RUN: begin
				err_set = start;
				if (tick && cyc_q == last) begin
					rdat_d = dir_q ? rdat_q : cap;
					done_set = 1'b1;
					state_d = ST_IDLE;
				end else if (tick) begin
					cyc_d = cyc_q + 4'd1;
				end
			end
			default: state_d = ST_IDLE;
		endcase
		claim_d = (state_d == ST_RUN) && uses_nand(cfg_q);
		// Pad image for the bus cycle that starts at this edge
		aph = cfg_q.mux && win(cyc_d, tw_q.adv_on, tw_q.adv_off);
		strb_d.chip_select_n = !win(cyc_d, tw_q.cs_on, tw_q.cs_off);
		strb_d.address_valid_n = !win(cyc_d, tw_q.adv_on, tw_q.adv_off);
		strb_d.write_enable_n = !(dir_q &&
			win(cyc_d, tw_q.we_on, tw_q.we_off));
		strb_d.output_enable_n = !(!dir_q &&
			win(cyc_d, tw_q.oe_on, tw_q.oe_off));
		strb_d.byte_lane_enable_n =
			win(cyc_d, tw_q.be_on, tw_q.be_off) ? ~m : 4'hf;
		lo_en = dir_q ? m[1:0] : 2'b00;
		hi_en = dir_q ? m[3:2] : 2'b00;
		ahi_d = aq_q[25:16];
		da_d = aq_q[15:0];
		nd_d = wq_q[15:0];
		dh_d = wq_q[31:16];
		nd_oe_d = ~lo_en;
		dh_oe_d = ~hi_en;
		da_oe_d = 2'b11;
		if (!cfg_q.mux) begin
			if (cfg_q.port_size_code == `EBL_DSZ_32)
				ahi_d[9] = 1'b0;
			if (cfg_q.port_size_code != `EBL_DSZ_32 && cfg_q.port_size_code != `EBL_DSZ_16HI)
				da_oe_d = 2'b00;
		end else begin
			// Shared pads: address phase, then data phase
			dh_oe_d = 2'b11;
			if (cfg_q.port_size_code == `EBL_DSZ_32) ahi_d = 10'h000;
			if (aph) begin
				da_oe_d = 2'b00;
				nd_d = {7'h00, aq_q[24:16]};
				nd_oe_d = (cfg_q.port_size_code == `EBL_DSZ_32) ? 2'b00 : 2'b11;
			end else begin
				da_d = wq_q[15:0];
				da_oe_d = ~lo_en;
				nd_d = wq_q[31:16];
				nd_oe_d = ~hi_en;
			end
		end
	end

	// Pads load only on a tick so, at a nonzero divide, every change meets a bus-clock rise
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= ST_IDLE;
			cfg_q <= `EBL_CTRL_RST;
			tw_q <= `EBL_TIM_RST;
			aq_q <= 32'h0000_0000;
			wq_q <= 32'h0000_0000;
			dir_q <= 1'b0;
			cyc_q <= 4'd0;
			rdat_q <= 32'h0000_0000;
			strobe <= `EBL_STRB_IDLE;
			addr_hi <= 10'h000;
			da_o <= 16'h0000;
			da_oe_n <= 2'b11;
			nand_shared_data_pins_o <= 16'h0000;
			nand_shared_data_pins_oe_n <= 2'b11;
			d_hi_o <= 16'h0000;
			d_hi_oe_n <= 2'b11;
			nand_claim <= 1'b0;
		end else begin
			state_q <= state_d;
			cfg_q <= cfg_d;
			tw_q <= tw_d;
			aq_q <= aq_d;
			wq_q <= wq_d;
			dir_q <= dir_d;
			cyc_q <= cyc_d;
			rdat_q <= rdat_d;
			nand_claim <= claim_d;
			if (state_d != ST_RUN) begin
				strobe <= `EBL_STRB_IDLE;
				da_oe_n <= 2'b11;
				nand_shared_data_pins_oe_n <= 2'b11;
				d_hi_oe_n <= 2'b11;
			end else if (tick) begin
				strobe <= strb_d;
				addr_hi <= ahi_d;
				da_o <= da_d;
				da_oe_n <= da_oe_d;
				nand_shared_data_pins_o <= nd_d;
				nand_shared_data_pins_oe_n <= nd_oe_d;
				d_hi_o <= dh_d;
				d_hi_oe_n <= dh_oe_d;
			end
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	logic [1:0] gap_q;
	logic dchg_q;
	logic run;

	// Cycles since the last tick, and whether the divider was rewritten
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gap_q <= 2'd0;
			dchg_q <= 1'b1;
		end else begin
			gap_q <= tick ? 2'd0 : gap_q + 2'd1;
			dchg_q <= (wr && paddr == `EBL_OFF_CTRL) ? 1'b1 :
				(tick ? 1'b0 : dchg_q);
		end
	end

	assign run = (state_q == ST_RUN);

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_last;
		run && tick && cyc_q == last;
	endsequence

	strobe_on_tick_a: assert property (
		$changed(strobe) && $past(run) && run |-> $past(tick))
		else $error("strobe moved off a bus clock edge");
	access_end_a: assert property (
		s_last |=> strobe == `EBL_STRB_IDLE && state_q == ST_IDLE)
		else $error("strobes not released at end of access");
	bclk_period_a: assert property (
		tick && !dchg_q |-> gap_q == ctrl_q.div)
		else $error("bus clock period wrong");
	bclk_rise_a: assert property (
		tick |=> bus_clk)
		else $error("bus clock not high after its edge");
	nand_owner_a: assert property (
		nand_shared_data_pins_oe_n != 2'b11 |-> nand_claim)
		else $error("shared pads driven without claim");
	claim_free_a: assert property (
		$rose(nand_claim) |-> !$past(nand_busy))
		else $error("claim taken while NAND busy");
	byte_map_a: assert property (
		strobe.byte_lane_enable_n != 4'hf |->
		~strobe.byte_lane_enable_n == lane_mask(cfg_q.mux, cfg_q.port_size_code))
		else $error("byte enables do not match port size");
	lane8_a: assert property (
		run && !cfg_q.mux && cfg_q.port_size_code == `EBL_DSZ_8B1 |->
		nand_shared_data_pins_oe_n[0] && d_hi_oe_n == 2'b11)
		else $error("8-bit lane 1 port drives a wrong lane");
	lane16_a: assert property (
		run && !cfg_q.mux && cfg_q.port_size_code == `EBL_DSZ_16HI |->
		nand_shared_data_pins_oe_n == 2'b11 && da_oe_n == 2'b11)
		else $error("16-bit high port drives low pads");
	addr25_a: assert property (
		run && !cfg_q.mux && cfg_q.port_size_code == `EBL_DSZ_32 |-> !addr_hi[9])
		else $error("32-bit port drives address bit 25");
	mux_addr_a: assert property (
		run && cfg_q.mux && !strobe.address_valid_n |->
		da_o == aq_q[15:0] && da_oe_n == 2'b00)
		else $error("address missing on shared pads");
	mux32_hi_a: assert property (
		run && cfg_q.mux && cfg_q.port_size_code == `EBL_DSZ_32 &&
		!strobe.address_valid_n |->
		nand_shared_data_pins_o == {7'h00, aq_q[24:16]})
		else $error("upper address missing on data pads");

endmodule

// ===== testbench/ebl_mem_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// Memory device on the far side of the pads
// ----------------------------------------
module ebl_mem_model (
	input wire logic pclk,
	input wire ebl_pkg::ebl_strb_t strobe,
	input wire logic mux,
	input wire logic [15:0] da_o,
	input wire logic [15:0] nd_o,
	input wire logic [15:0] hi_o,
	output logic [15:0] da_i,
	output logic [15:0] nd_i,
	output logic [15:0] hi_i
);
	import ebl_pkg::*;
	logic [31:0] mem_q = 32'h5a5a_c3c3;
	logic [15:0] last_da = 16'h0000;
	logic [15:0] last_nd = 16'h0000;
	logic [15:0] last_hi = 16'h0000;
	logic rd_on;
	logic [31:0] wr_word;
	logic [3:0] be;

	// Lane placement per bus arrangement
	assign rd_on = !strobe.chip_select_n && !strobe.output_enable_n;
	assign be = ~strobe.byte_lane_enable_n;
	assign wr_word = mux ? {nd_o, da_o} : {hi_o, nd_o};
	// Released lines flip every cycle, so a stale value never matches
	assign da_i = (rd_on && mux) ? mem_q[15:0] : ~last_da;
	assign nd_i = rd_on ? (mux ? mem_q[31:16] : mem_q[15:0]) : ~last_nd;
	assign hi_i = (rd_on && !mux) ? mem_q[31:16] : ~last_hi;

	// Bytes land only on enabled lanes during the data phase
	always @(posedge pclk) begin
		last_da <= da_i;
		last_nd <= nd_i;
		last_hi <= hi_i;
		if (!strobe.chip_select_n && !strobe.write_enable_n &&
			strobe.address_valid_n) begin
			for (int b = 0; b < 4; b++) begin
				if (be[b]) begin
					mem_q[8*b +: 8] <= wr_word[8*b +: 8];
				end
			end
		end
	end
endmodule

// ===== testbench/ebl_top_tb_top.sv
`timescale 1ns/1ps
`include "ebl_consts.svh"
module ebl_top_tb_top;
	import ebl_pkg::*;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic nand_busy = 1'b0;
	logic pready, pslverr, bus_clk, nand_claim, prev_bclk;
	logic [31:0] prdata;
	ebl_strb_t strobe, prev_strb;
	logic [9:0] addr_hi;
	logic [15:0] da_o, da_i, nd_o, nd_i, hi_o, hi_i;
	logic [1:0] da_oe_n, nd_oe_n, hi_oe_n;
	logic cur_mux = 1'b0;
	logic cur_wr = 1'b0;
	logic [2:0] cur_dsz = 3'h0;
	logic [1:0] cur_div = 2'h0;
	logic [25:0] cur_a = 26'h000_0000;
	logic [31:0] cur_w = 32'h0000_0000;
	logic mon_seen = 1'b0;
	logic [3:0] modes [8] = '{4'h8, 4'ha, 4'he, 4'h2, 4'h4, 4'h6, 4'h3, 4'h7};
	int cnt = 0;
	int error_cnt = 0;
	int n_compared = 0;

	always #10 pclk = ~pclk;

	ebl_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pready(pready), .prdata(prdata),
		.pslverr(pslverr), .bus_clk(bus_clk), .strobe(strobe),
		.addr_hi(addr_hi), .da_o(da_o), .da_oe_n(da_oe_n), .da_i(da_i),
		.nand_shared_data_pins_o(nd_o),
		.nand_shared_data_pins_oe_n(nd_oe_n),
		.nand_shared_data_pins_i(nd_i), .nand_busy(nand_busy),
		.nand_claim(nand_claim), .d_hi_o(hi_o), .d_hi_oe_n(hi_oe_n),
		.d_hi_i(hi_i));

	ebl_mem_model mem (.pclk(pclk), .strobe(strobe), .mux(cur_mux),
		.da_o(da_o), .nd_o(nd_o), .hi_o(hi_o), .da_i(da_i),
		.nd_i(nd_i), .hi_i(hi_i));

	// ----------------------------------------
	// Expectations, compare and closing
	// ----------------------------------------
	function logic [3:0] lane_mask(input logic [2:0] dz);
		case (dz)
			3'h4: lane_mask = 4'h1;
			3'h5: lane_mask = 4'h2;
			3'h7: lane_mask = 4'h8;
			3'h1: lane_mask = 4'h3;
			3'h2: lane_mask = 4'hc;
			3'h3: lane_mask = 4'hf;
			default: lane_mask = 4'h0;
		endcase
	endfunction

	function logic [31:0] byte_mask(input logic [3:0] m);
		return {{8{m[3]}}, {8{m[2]}}, {8{m[1]}}, {8{m[0]}}};
	endfunction

	task cmp(input string what, input logic [31:0] x, input logic [31:0] g);
		n_compared++;
		if (g !== x) begin
			error_cnt++;
			$display("FAIL %s expected %h seen %h", what, x, g);
		end
	endtask

	task test_done();
		$display("compared %0d mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// APB master: holds the request until pready is sampled high
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		int i;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		for (i = 0; i < 20; i++) begin
			@(posedge pclk);
			if (pready === 1'b1) break;
		end
		if (i == 20) begin
			cmp("pready wait", 1, 0);
			test_done();
		end
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic e;
		apb(1'b1, a, d, r, e);
	endtask

	task rd_chk(input logic [11:0] a, input logic [31:0] x, input logic xe);
		logic [31:0] r;
		logic e;
		apb(1'b0, a, 32'h0000_0000, r, e);
		cmp("prdata", x, r);
		cmp("pslverr", xe, e);
	endtask

	// Access start: mode, address, data, then the command
	task start_acc(input logic m, input logic [2:0] dz, input logic [1:0] dv,
		input logic w, input logic [25:0] a, input logic [31:0] d);
		cur_mux = m;
		cur_dsz = dz;
		cur_wr = w;
		cur_a = a;
		cur_w = d;
		wr(`EBL_OFF_CTRL, {22'h0, 4'h3, dv, dz, m});
		// Period straddling a divider change is irregular: restart count
		mon_seen = 1'b0;
		cur_div = dv;
		wr(`EBL_OFF_ADDR, {6'h0, a});
		wr(`EBL_OFF_WDATA, d);
		wr(`EBL_OFF_CMD, {30'h0, w, 1'b1});
	endtask

	// Access end: bounded poll for done, idle pads, read data
	task finish_acc();
		int i;
		logic [31:0] r;
		logic e;
		for (i = 0; i < 60; i++) begin
			apb(1'b0, `EBL_OFF_STATUS, 32'h0000_0000, r, e);
			if (r[2] === 1'b1) break;
		end
		if (i == 60) begin
			cmp("done wait", 1, 0);
			test_done();
		end
		cmp("idle strobe", 8'hff, strobe);
		cmp("idle oe", 6'h3f, {da_oe_n, nd_oe_n, hi_oe_n});
		cmp("idle claim", 0, nand_claim);
		if (!cur_wr) rd_chk(`EBL_OFF_RDATA,
			cur_w & byte_mask(lane_mask(cur_dsz)), 0);
		wr(`EBL_OFF_STATUS, 32'h0000_0004);
	endtask

	// Pin monitor; a rise is seen one sample late, so counts are exact
	always @(posedge pclk) begin
		if (presetn === 1'b1) begin
			if (bus_clk === 1'b1 && prev_bclk === 1'b0) begin
				if (mon_seen && cur_div != 2'h0)
					cmp("bus period", cur_div + 1, cnt);
				mon_seen = 1'b1;
				cnt = 1;
			end else begin
				cnt++;
			end
			if (cur_div != 2'h0 && strobe !== prev_strb)
				cmp("strobe edge", 1, {bus_clk, prev_bclk} === 2'b10);
			if (strobe.byte_lane_enable_n !== 4'hf) cmp("byte enables",
				4'(~lane_mask(cur_dsz)), strobe.byte_lane_enable_n);
			if (nd_oe_n !== 2'b11) cmp("nand claim", 1, nand_claim);
			if (cur_mux && !strobe.address_valid_n) begin
				cmp("muxed addr", cur_a[15:0], da_o);
				if (cur_dsz == 3'h3)
					cmp("muxed upper", {7'h0, cur_a[24:16]}, nd_o);
			end
			if (!cur_mux && !strobe.chip_select_n) begin
				cmp("addr hi", (cur_dsz == 3'h3) ? {1'b0, cur_a[24:16]} :
					cur_a[25:16], addr_hi);
				if (cur_dsz == 3'h2 || cur_dsz == 3'h3)
					cmp("da released", 2'b11, da_oe_n);
				else
					cmp("sep addr", cur_a[15:0], da_o);
			end
		end
		prev_strb = strobe;
		prev_bclk = bus_clk;
	end

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		logic [25:0] a;
		void'($urandom(32'h497d253b));
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rd_chk(`EBL_OFF_CTRL, 32'h0000_0202, 0);
		rd_chk(`EBL_OFF_TIMING, 32'h39e7_9238, 0);
		rd_chk(12'h01c, 32'h0000_0000, 1);
		wr(`EBL_OFF_TIMING, 32'h1965_9218);
		$display("test registers done");
		// Muxed 8-bit is no legal arrangement: refused, error flagged
		wr(`EBL_OFF_CTRL, 32'h0000_00c9);
		wr(`EBL_OFF_CMD, 32'h0000_0001);
		rd_chk(`EBL_OFF_STATUS, 32'h0000_0002, 0);
		wr(`EBL_OFF_STATUS, 32'h0000_0002);
		rd_chk(`EBL_OFF_STATUS, 32'h0000_0000, 0);
		$display("test refused mode done");
		// Shared pads held by NAND: nothing may start until released
		nand_busy <= 1'b1;
		start_acc(1'b0, 3'h1, 2'h1, 1'b1, 26'h155_a5a5, 32'hdead_beef);
		repeat (20) @(posedge pclk);
		cmp("held select", 1, strobe.chip_select_n);
		cmp("held claim", 0, nand_claim);
		nand_busy <= 1'b0;
		finish_acc();
		start_acc(1'b0, 3'h1, 2'h1, 1'b0, 26'h155_a5a5, 32'h0);
		cur_w = 32'hdead_beef;
		finish_acc();
		$display("test nand sharing done");
		// Every arrangement, write then read back, all-ones address first
		for (int k = 0; k < 16; k++) begin
			a = (k < 8) ? 26'h3ff_ffff : 26'($urandom);
			start_acc(modes[k%8][0], modes[k%8][3:1], 2'($urandom), 1'b1,
				a, $urandom);
			finish_acc();
			start_acc(cur_mux, cur_dsz, cur_div, 1'b0, a, cur_w);
			finish_acc();
		end
		$display("test lane map done");
		test_done();
	end
endmodule
